// *** src/sior_config_regs.sv ***
// configuration registers 0x0d..0x17: id, revision, test, config port
// base, run-time shadows and the forced floppy status register.
// assumes: io strobes are one-cycle pulses on CLK; floppy and strap pins
// are asynchronous; config state entry/exit is decoded elsewhere.
//
// Behaviour
// R01: read-only device id at 0x0d
// R02: read-only chip revision at 0x0e
// R03: test registers reset 00, 00, 80
// R04: host leaves test registers alone
// R05: base address from 0x12 and 0x13
// R06: base address bit zero forced low
// R07: decode moves only on 0x13 write
// R08: host writes 0x12 before 0x13
// R09: strap picks low reset, high 0x03
// R10: 0x14 shadows floppy rate select
// R11: 0x15 shadows uart1 fifo control
// R12: 0x16 shadows uart2 fifo control
// R13: access only in config state, index
// R14: force status at 0x17, reset 03
// R15: forced change drives change when selected
// R16: software sets change bits, never clears
// R17: step with select clears change bit
// R18: dir bit 7 ors three terms
// R19: controls apply native and parallel path
// R20: forced lock asserts write lock input when any drive selected
// R21: read-only writes ignored, reserved read zero
`timescale 1ns/1ps
`default_nettype none
`include "sior_regs.svh"
module sior_config_regs (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic CONFIG_STATE,
	input wire logic [15:0] IO_ADDR,
	input wire logic [7:0] IO_WDATA,
	input wire logic IO_WR,
	input wire logic IO_RD,
	output logic [7:0] IO_RDATA,
	output logic IO_RDATA_OE,
	output logic [10:0] CONFIG_BASE,
	output logic [7:0] CONFIG_INDEX,
	input wire logic CONFIG_PORT_STRAP,
	input wire sior_pkg::sior_shadow_type FDC_RATE_SHADOW,
	input wire sior_pkg::sior_shadow_type UART1_FIFO_CONTROL,
	input wire sior_pkg::sior_shadow_type UART2_FIFO_CONTROL,
	input wire logic HEAD_STEP_PULSE_N,
	input wire logic DRIVE_ZERO_SELECT_N,
	input wire logic DRIVE_ONE_SELECT_N,
	input wire logic DISK_CHANGE_INPUT_N,
	input wire logic WRITE_LOCK_INPUT_N,
	input wire logic PP_HEAD_STEP_PULSE_N,
	input wire logic PP_DRIVE_ZERO_SELECT_N,
	input wire logic PP_DRIVE_ONE_SELECT_N,
	input wire logic PP_DISK_CHANGE_INPUT_N,
	input wire logic PP_WRITE_LOCK_INPUT_N,
	output sior_pkg::sior_fdd_status_type FLOPPY_CONTROLLER_STATUS,
	output sior_pkg::sior_fdd_status_type PP_FLOPPY_CONTROLLER_STATUS
);

	// pin synchronisers
	wire logic [`SIOR_SYNC_WIDTH-1:0] pin_raw;
	logic [`SIOR_SYNC_WIDTH-1:0] sync1_reg;
	logic [`SIOR_SYNC_WIDTH-1:0] sync2_reg;
	logic strap_sync1_reg;
	logic strap_sync2_reg;

	// boot sequencing for the strap load
	sior_pkg::sior_boot_type boot_reg;
	sior_pkg::sior_boot_type boot_next;
	logic [1:0] settle_reg;
	logic [1:0] settle_next;
	wire logic boot_load;
	wire logic boot_done;

	// registers
	logic [7:0] index_reg;
	logic [7:0] test_a_reg;
	logic [7:0] test_b_reg;
	logic [7:0] test_c_reg;
	logic [7:0] base_low_reg;
	logic [7:0] base_high_reg;
	logic [10:0] base_reg;
	logic [7:0] rate_shadow_reg;
	logic [7:0] uart1_shadow_reg;
	logic [7:0] uart2_shadow_reg;
	logic [7:0] force_reg;
	logic [7:0] force_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic rdata_oe_reg;

	// decode
	wire logic upper_zero;
	wire logic port_hit;
	wire logic index_port;
	wire logic data_port;
	wire logic data_access;
	wire logic wr_index;
	wire logic wr_data;
	wire logic rd_hit;
	wire logic wr_test_a;
	wire logic wr_test_b;
	wire logic wr_test_c;
	wire logic wr_base_low;
	wire logic wr_base_high;
	wire logic wr_force;
	wire logic [10:0] base_from_regs;
	wire logic [7:0] strap_low;

	// drive status paths
	sior_pkg::sior_fdd_pins_type path_pins [2];
	sior_pkg::sior_fdd_status_type path_status [2];
	wire logic [1:0] clear0;
	wire logic [1:0] clear1;
	wire logic clear_change0;
	wire logic clear_change1;

	assign pin_raw = {
		PP_WRITE_LOCK_INPUT_N,
		PP_DISK_CHANGE_INPUT_N,
		PP_DRIVE_ONE_SELECT_N,
		PP_DRIVE_ZERO_SELECT_N,
		PP_HEAD_STEP_PULSE_N,
		WRITE_LOCK_INPUT_N,
		DISK_CHANGE_INPUT_N,
		DRIVE_ONE_SELECT_N,
		DRIVE_ZERO_SELECT_N,
		HEAD_STEP_PULSE_N
	};

	// idle pins are high, so the chain resets to high
	genvar gi;
	generate
		for (gi = 0; gi < `SIOR_SYNC_WIDTH; gi = gi + 1) begin : g_sync
			always_ff @(posedge CLK or negedge ARST_N) begin
				if (!ARST_N) begin
					sync1_reg[gi] <= 1'b1;
					sync2_reg[gi] <= 1'b1;
				end else begin
					sync1_reg[gi] <= pin_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			strap_sync1_reg <= 1'b0;
			strap_sync2_reg <= 1'b0;
		end else begin
			strap_sync1_reg <= CONFIG_PORT_STRAP;
			strap_sync2_reg <= strap_sync1_reg;
		end
	end

	// strap is sampled only after the synchroniser has filled
	always_comb begin
		boot_next = boot_reg;
		settle_next = settle_reg;
		case (boot_reg)
			sior_pkg::BOOT_SETTLE: begin
				settle_next = settle_reg + 2'h1;
				if (settle_reg == `SIOR_STRAP_SETTLE) begin
					boot_next = sior_pkg::BOOT_LOAD;
				end
			end
			sior_pkg::BOOT_LOAD: begin
				boot_next = sior_pkg::BOOT_RUN;
			end
			default: begin
				boot_next = sior_pkg::BOOT_RUN;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			boot_reg <= sior_pkg::BOOT_SETTLE;
			settle_reg <= 2'h0;
		end else begin
			boot_reg <= boot_next;
			settle_reg <= settle_next;
		end
	end

	assign boot_load = (boot_reg == sior_pkg::BOOT_LOAD);
	assign boot_done = (boot_reg == sior_pkg::BOOT_RUN);

	// R09 strap selects low byte
	assign strap_low = strap_sync2_reg ? `SIOR_BASE_LOW_STRAP1 :
		`SIOR_BASE_LOW_STRAP0;

	// R05 R06 even base address, upper bits from the 0x13 write
	assign base_from_regs = {IO_WDATA[`SIOR_BASE_HIGH_MSB:0],
		base_low_reg[7:1], 1'b0};

	// 16 bit qualification: address bits above the base must be zero
	assign upper_zero = (IO_ADDR[15:11] == `SIOR_UPPER_ADDR_ZERO);
	assign port_hit = upper_zero & (IO_ADDR[10:1] == base_reg[10:1]) &
		boot_done;
	assign index_port = port_hit & ~IO_ADDR[0];
	assign data_port = port_hit & IO_ADDR[0];

	// R13 config state gating
	assign data_access = data_port & CONFIG_STATE;
	assign wr_index = IO_WR & index_port & CONFIG_STATE;
	assign wr_data = IO_WR & data_access;
	assign rd_hit = IO_RD & CONFIG_STATE & (index_port | data_port);

	// R21 read-only indexes get no write strobe
	assign wr_test_a = wr_data & (index_reg == `SIOR_IDX_TEST_A);
	assign wr_test_b = wr_data & (index_reg == `SIOR_IDX_TEST_B);
	assign wr_test_c = wr_data & (index_reg == `SIOR_IDX_TEST_C);
	assign wr_base_low = wr_data & (index_reg == `SIOR_IDX_BASE_LOW);
	assign wr_base_high = wr_data & (index_reg == `SIOR_IDX_BASE_HIGH);
	assign wr_force = wr_data & (index_reg == `SIOR_IDX_FORCE_STATUS);

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			index_reg <= `SIOR_INDEX_RESET;
		end else if (wr_index) begin
			index_reg <= IO_WDATA;
		end
	end

	// R03 test register defaults
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			test_a_reg <= `SIOR_TEST_A_RESET;
			test_b_reg <= `SIOR_TEST_B_RESET;
			test_c_reg <= `SIOR_TEST_C_RESET;
		end else begin
			if (wr_test_a) begin
				test_a_reg <= IO_WDATA;
			end
			if (wr_test_b) begin
				test_b_reg <= IO_WDATA;
			end
			if (wr_test_c) begin
				test_c_reg <= IO_WDATA;
			end
		end
	end

	// R09 base registers from strap after release
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			base_low_reg <= `SIOR_BASE_LOW_STRAP0;
			base_high_reg <= `SIOR_BASE_HIGH_RESET;
		end else if (boot_load) begin
			base_low_reg <= strap_low;
			base_high_reg <= `SIOR_BASE_HIGH_RESET;
		end else begin
			if (wr_base_low) begin
				base_low_reg <= IO_WDATA & `SIOR_BASE_LOW_MASK;
			end
			if (wr_base_high) begin
				base_high_reg <= IO_WDATA & `SIOR_BASE_HIGH_MASK;
			end
		end
	end

	// R07 decode moves on 0x13 write only
	// a lone low-byte write leaves the live decode where it was, so the
	// host never loses the ports halfway through a move
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			base_reg <= `SIOR_CONFIG_BASE_RESET;
		end else if (boot_load) begin
			base_reg <= {base_high_reg[`SIOR_BASE_HIGH_MSB:0],
				strap_low[7:1], 1'b0};
		end else if (wr_base_high) begin
			base_reg <= base_from_regs;
		end
	end

	// R10 R11 R12 run-time shadows
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rate_shadow_reg <= `SIOR_SHADOW_RESET;
			uart1_shadow_reg <= `SIOR_SHADOW_RESET;
			uart2_shadow_reg <= `SIOR_SHADOW_RESET;
		end else begin
			if (FDC_RATE_SHADOW.wr) begin
				rate_shadow_reg <= FDC_RATE_SHADOW.data & `SIOR_RATE_MASK;
			end
			if (UART1_FIFO_CONTROL.wr) begin
				uart1_shadow_reg <= UART1_FIFO_CONTROL.data &
					`SIOR_FIFO_CTRL_MASK;
			end
			if (UART2_FIFO_CONTROL.wr) begin
				uart2_shadow_reg <= UART2_FIFO_CONTROL.data &
					`SIOR_FIFO_CTRL_MASK;
			end
		end
	end

	// R19 clears from both paths
	assign clear_change0 = |clear0;
	assign clear_change1 = |clear1;

	always_comb begin
		force_next = force_reg;
		// R17 hardware clear on step
		if (clear_change0) begin
			force_next[`SIOR_FORCE_CHG0_BIT] = 1'b0;
		end
		if (clear_change1) begin
			force_next[`SIOR_FORCE_CHG1_BIT] = 1'b0;
		end
		if (wr_force) begin
			// R16 set only, software set wins over step clear
			if (IO_WDATA[`SIOR_FORCE_CHG0_BIT]) begin
				force_next[`SIOR_FORCE_CHG0_BIT] = 1'b1;
			end
			if (IO_WDATA[`SIOR_FORCE_CHG1_BIT]) begin
				force_next[`SIOR_FORCE_CHG1_BIT] = 1'b1;
			end
			force_next[`SIOR_FORCE_LOCK_BIT] =
				IO_WDATA[`SIOR_FORCE_LOCK_BIT];
		end
		// R21 reserved bits stay zero
		force_next = force_next & `SIOR_FORCE_MASK;
	end

	// R14 force status reset 03
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			force_reg <= `SIOR_FORCE_RESET;
		end else begin
			force_reg <= force_next;
		end
	end

	// R19 one status merge per path
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_path
			assign path_pins[gi].step = ~sync2_reg[gi*5];
			assign path_pins[gi].sel0 = ~sync2_reg[gi*5+1];
			assign path_pins[gi].sel1 = ~sync2_reg[gi*5+2];
			assign path_pins[gi].dskchg = ~sync2_reg[gi*5+3];
			assign path_pins[gi].wrtprt = ~sync2_reg[gi*5+4];
			// R15 R18 R20 forced inputs
			sior_drive_status u_status (
				.clk(CLK),
				.arst_n(ARST_N),
				.pins(path_pins[gi]),
				.force_change0(force_reg[`SIOR_FORCE_CHG0_BIT]),
				.force_change1(force_reg[`SIOR_FORCE_CHG1_BIT]),
				.force_lock(force_reg[`SIOR_FORCE_LOCK_BIT]),
				.clear_change0(clear0[gi]),
				.clear_change1(clear1[gi]),
				.status(path_status[gi])
			);
		end
	endgenerate

	assign FLOPPY_CONTROLLER_STATUS = path_status[0];
	assign PP_FLOPPY_CONTROLLER_STATUS = path_status[1];

	// read data; index port reads back the index
	always_comb begin
		rdata_next = 8'h00;
		if (index_port) begin
			rdata_next = index_reg;
		// R01 fixed device id
		end else if (index_reg == `SIOR_IDX_DEVICE_ID) begin
			rdata_next = `SIOR_DEVICE_ID_VALUE;
		// R02 revision level
		end else if (index_reg == `SIOR_IDX_CHIP_REV) begin
			rdata_next = `SIOR_CHIP_REV_VALUE;
		end else if (index_reg == `SIOR_IDX_TEST_A) begin
			rdata_next = test_a_reg;
		end else if (index_reg == `SIOR_IDX_TEST_B) begin
			rdata_next = test_b_reg;
		end else if (index_reg == `SIOR_IDX_TEST_C) begin
			rdata_next = test_c_reg;
		end else if (index_reg == `SIOR_IDX_BASE_LOW) begin
			rdata_next = base_low_reg;
		end else if (index_reg == `SIOR_IDX_BASE_HIGH) begin
			rdata_next = base_high_reg;
		end else if (index_reg == `SIOR_IDX_RATE_SHADOW) begin
			rdata_next = rate_shadow_reg;
		end else if (index_reg == `SIOR_IDX_UART1_SHADOW) begin
			rdata_next = uart1_shadow_reg;
		end else if (index_reg == `SIOR_IDX_UART2_SHADOW) begin
			rdata_next = uart2_shadow_reg;
		end else if (index_reg == `SIOR_IDX_FORCE_STATUS) begin
			rdata_next = force_reg;
		end
	end

	// other indexes belong to neighbouring slices: no drive from here
	wire logic own_index;
	assign own_index = index_port |
		((index_reg >= `SIOR_IDX_DEVICE_ID) &&
		(index_reg <= `SIOR_IDX_FORCE_STATUS));

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rdata_reg <= 8'h00;
			rdata_oe_reg <= 1'b0;
		end else begin
			rdata_reg <= (rd_hit & own_index) ? rdata_next : 8'h00;
			rdata_oe_reg <= rd_hit & own_index;
		end
	end

	assign IO_RDATA = rdata_reg;
	assign IO_RDATA_OE = rdata_oe_reg;
	assign CONFIG_BASE = base_reg;
	assign CONFIG_INDEX = index_reg;

endmodule
`default_nettype wire

// *** src/sior_regs.svh ***
// register indexes, reset values, field positions and counts for the
// configuration slice at indexes 0x0d to 0x17.
// assumes: included by bare name from the package and the design files.
`ifndef SIOR_REGS_SVH
`define SIOR_REGS_SVH

`define SIOR_IDX_DEVICE_ID 8'h0d
`define SIOR_IDX_CHIP_REV 8'h0e
`define SIOR_IDX_TEST_A 8'h0f
`define SIOR_IDX_TEST_B 8'h10
`define SIOR_IDX_TEST_C 8'h11
`define SIOR_IDX_BASE_LOW 8'h12
`define SIOR_IDX_BASE_HIGH 8'h13
`define SIOR_IDX_RATE_SHADOW 8'h14
`define SIOR_IDX_UART1_SHADOW 8'h15
`define SIOR_IDX_UART2_SHADOW 8'h16
`define SIOR_IDX_FORCE_STATUS 8'h17

// arbitrary identification values
`define SIOR_DEVICE_ID_VALUE 8'h5a
`define SIOR_CHIP_REV_VALUE 8'h00

`define SIOR_TEST_A_RESET 8'h00
`define SIOR_TEST_B_RESET 8'h00
`define SIOR_TEST_C_RESET 8'h80
`define SIOR_BASE_LOW_STRAP0 8'hf0
`define SIOR_BASE_LOW_STRAP1 8'h70
`define SIOR_BASE_HIGH_RESET 8'h03
`define SIOR_FORCE_RESET 8'h03
`define SIOR_SHADOW_RESET 8'h00
`define SIOR_INDEX_RESET 8'h00
`define SIOR_CONFIG_BASE_RESET 11'h3f0
`define SIOR_STATUS_RESET 3'h6

`define SIOR_FORCE_CHG0_BIT 0
`define SIOR_FORCE_CHG1_BIT 1
`define SIOR_FORCE_LOCK_BIT 2
`define SIOR_BASE_HIGH_MSB 2
`define SIOR_BASE_HIGH_MASK 8'h07
`define SIOR_BASE_LOW_MASK 8'hfe
`define SIOR_RATE_MASK 8'hdf
`define SIOR_FIFO_CTRL_MASK 8'hcf
`define SIOR_FORCE_MASK 8'h07

`define SIOR_UPPER_ADDR_ZERO 5'h00
`define SIOR_STRAP_SETTLE 2'h3
`define SIOR_SYNC_WIDTH 10

`endif

// *** src/sior_pkg.sv ***
// types shared by the configuration slice and its drive status helper.
// assumes: compiled before every design file.
`include "sior_regs.svh"
package sior_pkg;

	typedef struct packed {
		logic wr;
		logic [7:0] data;
	} sior_shadow_type;

	// floppy pin levels after synchronising, active high
	typedef struct packed {
		logic step;
		logic sel0;
		logic sel1;
		logic dskchg;
		logic wrtprt;
	} sior_fdd_pins_type;

	// internal floppy controller inputs, active low, plus dir bit 7
	typedef struct packed {
		logic disk_change_n;
		logic write_lock_n;
		logic dir_disk_change;
	} sior_fdd_status_type;

	typedef enum logic [1:0] {
		BOOT_SETTLE,
		BOOT_LOAD,
		BOOT_RUN
	} sior_boot_type;

endpackage

// *** src/sior_drive_status.sv ***
// forced disk change and write lock merge for one floppy path.
// assumes: pin levels already synchronised and active high.
`timescale 1ns/1ps
`default_nettype none
`include "sior_regs.svh"
module sior_drive_status (
	input wire logic clk,
	input wire logic arst_n,
	input wire sior_pkg::sior_fdd_pins_type pins,
	input wire logic force_change0,
	input wire logic force_change1,
	input wire logic force_lock,
	output logic clear_change0,
	output logic clear_change1,
	output sior_pkg::sior_fdd_status_type status
);

	wire logic any_select;
	wire logic change_active;
	wire logic lock_active;
	sior_pkg::sior_fdd_status_type status_next;

	// R17 step clears
	assign clear_change0 = pins.step & pins.sel0;
	assign clear_change1 = pins.step & pins.sel1;

	assign any_select = pins.sel0 | pins.sel1;
	// R15 R18 selected drive change
	assign change_active = (pins.sel0 & force_change0) |
		(pins.sel1 & force_change1) | pins.dskchg;
	// R20 forced write lock
	assign lock_active = (force_lock & any_select) | pins.wrtprt;

	assign status_next.disk_change_n = ~change_active;
	assign status_next.write_lock_n = ~lock_active;
	assign status_next.dir_disk_change = change_active;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status <= `SIOR_STATUS_RESET;
		end else begin
			status <= status_next;
		end
	end

endmodule
`default_nettype wire

// *** test/sior_host_model.sv ***
// host model: byte cycles on the config index and data ports.
// assumes: clk is the design clock; base kept by the caller.
`timescale 1ns/1ps
`default_nettype none
module sior_host_model (
	input wire logic clk,
	input wire logic [7:0] rdata,
	input wire logic oe,
	output logic [15:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd
);
	initial begin
		addr = 16'h0000;
		wdata = 8'h00;
		wr = 1'h0;
		rd = 1'h0;
	end
	// config state is left to the caller, test regs never written
	task automatic io_write(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
		// released bus must not keep a valid look
		addr <= ~a;
		wdata <= ~d;
		#1;
	endtask
	task automatic io_read(input logic [15:0] a, output logic [7:0] d,
		output logic ok);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		addr <= ~a;
		#1;
		d = rdata;
		ok = oe;
	endtask
	// low byte first, high byte moves decode
	task automatic move_base(input logic [15:0] b, input logic [10:0] nb);
		io_write(b, 8'h12);
		io_write(b | 16'h0001, nb[7:0]);
		io_write(b, 8'h13);
		io_write(b | 16'h0001, {5'h00, nb[10:8]});
	endtask
endmodule
`default_nettype wire

// *** test/sior_config_regs_properties.sv ***
// checker on the config slice top ports.
// assumes: bound into sior_config_regs, one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "sior_regs.svh"
module sior_props (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic CONFIG_STATE,
	input wire logic [15:0] IO_ADDR,
	input wire logic IO_WR,
	input wire logic IO_RD,
	input wire logic [7:0] IO_RDATA,
	input wire logic IO_RDATA_OE,
	input wire logic [10:0] CONFIG_BASE,
	input wire logic [7:0] CONFIG_INDEX,
	input wire logic DRIVE_ZERO_SELECT_N,
	input wire logic DRIVE_ONE_SELECT_N,
	input wire logic DISK_CHANGE_INPUT_N,
	input wire sior_pkg::sior_fdd_status_type FLOPPY_CONTROLLER_STATUS
);
	logic [3:0] up_cnt_reg;
	logic run_ok;
	logic data_rd;
	logic in_range;
	// boot load moves the base, so base checks wait it out
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			up_cnt_reg <= 4'h0;
		end else if (!run_ok) begin
			up_cnt_reg <= up_cnt_reg + 4'h1;
		end
	end
	assign run_ok = up_cnt_reg == 4'ha;
	assign data_rd = run_ok && IO_RD && CONFIG_STATE &&
		IO_ADDR == {5'h00, CONFIG_BASE[10:1], 1'h1};
	assign in_range = CONFIG_INDEX >= 8'h0d && CONFIG_INDEX <= 8'h17;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);
	a_oe_from_read: assert property (IO_RDATA_OE |-> $past(IO_RD && CONFIG_STATE))
		else $error("read data without a taken read");
	a_idle_zero: assert property (!IO_RDATA_OE |-> IO_RDATA == 8'h00)
		else $error("read data not zero when idle");
	a_base_even: assert property (CONFIG_BASE[0] == 1'h0)
		else $error("config base odd");
	a_base_moves: assert property (run_ok && $changed(CONFIG_BASE) |->
		$past(IO_WR && IO_ADDR[0] && CONFIG_INDEX == 8'h13))
		else $error("base moved without high byte write");
	a_id_read: assert property (data_rd && CONFIG_INDEX == 8'h0d |=>
		IO_RDATA_OE && IO_RDATA == `SIOR_DEVICE_ID_VALUE)
		else $error("device id read wrong");
	a_range_answer: assert property (data_rd && in_range |=> IO_RDATA_OE)
		else $error("in range read not answered");
	a_range_refuse: assert property (data_rd && !in_range |=> !IO_RDATA_OE)
		else $error("out of range read answered");
	a_force_rsvd: assert property (data_rd && CONFIG_INDEX == 8'h17 |=>
		IO_RDATA[7:3] == 5'h00)
		else $error("force status reserved bits set");
	a_change_pin: assert property (!DISK_CHANGE_INPUT_N [*5] |->
		FLOPPY_CONTROLLER_STATUS.dir_disk_change)
		else $error("external change not in dir bit");
	a_no_select: assert property ((DRIVE_ZERO_SELECT_N && DRIVE_ONE_SELECT_N &&
		DISK_CHANGE_INPUT_N) [*5] |-> FLOPPY_CONTROLLER_STATUS.disk_change_n)
		else $error("change active with no drive selected");
	c_id_read: cover property (data_rd && CONFIG_INDEX == 8'h0d);
	c_base_move: cover property (run_ok && $changed(CONFIG_BASE));
	c_forced: cover property (!DRIVE_ZERO_SELECT_N &&
		FLOPPY_CONTROLLER_STATUS.dir_disk_change);
endmodule
`default_nettype wire

// *** test/sior_config_regs_tb_top.sv ***
// top bench: host model on the config ports, floppy pins, shadow strobes.
// assumes: strap low at first boot (base 0x3f0), high after mid-run reset.
`timescale 1ns/1ps
`default_nettype none
`include "sior_regs.svh"
module sior_config_regs_tb_top;
	logic clk = 1'h0;
	logic arst_n = 1'h0;
	logic cfg = 1'h1;
	logic strap = 1'h0;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic wr;
	logic rd;
	logic oe;
	logic [10:0] base;
	logic [10:0] cur_base = 11'h3f0;
	sior_pkg::sior_shadow_type rate_sh = '0;
	sior_pkg::sior_shadow_type u1_sh = '0;
	sior_pkg::sior_shadow_type u2_sh = '0;
	// step, select 0, select 1, change, lock; all active low
	logic [4:0] pin_n = 5'h1f;
	logic [4:0] pp_n = 5'h1f;
	sior_pkg::sior_fdd_status_type st;
	sior_pkg::sior_fdd_status_type pp_st;
	int err_total = 0;
	int num_checks = 0;
	always #10 clk = ~clk;
	sior_config_regs DUT (.CLK(clk), .ARST_N(arst_n), .CONFIG_STATE(cfg),
		.IO_ADDR(addr), .IO_WDATA(wdata), .IO_WR(wr), .IO_RD(rd),
		.IO_RDATA(rdata), .IO_RDATA_OE(oe), .CONFIG_BASE(base),
		.CONFIG_INDEX(), .CONFIG_PORT_STRAP(strap), .FDC_RATE_SHADOW(rate_sh),
		.UART1_FIFO_CONTROL(u1_sh), .UART2_FIFO_CONTROL(u2_sh),
		.HEAD_STEP_PULSE_N(pin_n[4]), .DRIVE_ZERO_SELECT_N(pin_n[3]),
		.DRIVE_ONE_SELECT_N(pin_n[2]), .DISK_CHANGE_INPUT_N(pin_n[1]),
		.WRITE_LOCK_INPUT_N(pin_n[0]), .PP_HEAD_STEP_PULSE_N(pp_n[4]),
		.PP_DRIVE_ZERO_SELECT_N(pp_n[3]), .PP_DRIVE_ONE_SELECT_N(pp_n[2]),
		.PP_DISK_CHANGE_INPUT_N(pp_n[1]), .PP_WRITE_LOCK_INPUT_N(pp_n[0]),
		.FLOPPY_CONTROLLER_STATUS(st), .PP_FLOPPY_CONTROLLER_STATUS(pp_st));
	sior_host_model host (.clk(clk), .rdata(rdata), .oe(oe), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chkv(input logic [10:0] got, input logic [10:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkf(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_reg(input logic [7:0] i, output logic [7:0] d,
		output logic ok);
		host.io_write({5'h00, cur_base}, i);
		host.io_read({5'h00, cur_base} | 16'h0001, d, ok);
	endtask
	task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
		host.io_write({5'h00, cur_base}, i);
		host.io_write({5'h00, cur_base} | 16'h0001, d);
	endtask
	task automatic expect_reg(input logic [7:0] i, input logic [7:0] e);
		logic [7:0] d;
		logic ok;
		rd_reg(i, d, ok);
		chkf(ok, 1'h1);
		chkv(11'(d), 11'(e));
	endtask
	// floppy pins settle through sync and register
	task automatic pins(input logic [4:0] n, input logic [4:0] p);
		@(posedge clk);
		pin_n <= n;
		pp_n <= p;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic t_defaults();
		chkv(base, 11'h3f0);
		expect_reg(8'h0d, `SIOR_DEVICE_ID_VALUE);
		expect_reg(8'h0e, `SIOR_CHIP_REV_VALUE);
		expect_reg(8'h0f, 8'h00);
		expect_reg(8'h10, 8'h00);
		expect_reg(8'h11, 8'h80);
		expect_reg(8'h12, 8'hf0);
		expect_reg(8'h13, 8'h03);
		expect_reg(8'h17, 8'h03);
	endtask
	task automatic t_shadows();
		wr_reg(8'h0d, 8'hff);
		expect_reg(8'h0d, `SIOR_DEVICE_ID_VALUE);
		@(posedge clk);
		rate_sh <= {1'h1, 8'hff};
		u1_sh <= {1'h1, 8'hff};
		u2_sh <= {1'h1, 8'hc9};
		@(posedge clk);
		rate_sh.wr <= 1'h0;
		u1_sh.wr <= 1'h0;
		u2_sh.wr <= 1'h0;
		wr_reg(8'h14, 8'h00);
		expect_reg(8'h14, 8'hdf);
		expect_reg(8'h15, 8'hcf);
		expect_reg(8'h16, 8'hc9);
	endtask
	task automatic t_move();
		wr_reg(8'h12, 8'h61);
		chkv(base, 11'h3f0);
		wr_reg(8'h13, 8'hfa);
		@(posedge clk);
		#1;
		cur_base = 11'h260;
		chkv(base, cur_base);
		expect_reg(8'h12, 8'h60);
		expect_reg(8'h13, 8'h02);
		host.move_base({5'h00, cur_base}, 11'h3f0);
		cur_base = 11'h3f0;
		expect_reg(8'h13, 8'h03);
	endtask
	task automatic t_refuse();
		logic [7:0] d;
		logic ok;
		@(posedge clk);
		cfg <= 1'h0;
		rd_reg(8'h0d, d, ok);
		chkf(ok, 1'h0);
		@(posedge clk);
		cfg <= 1'h1;
		rd_reg(8'h18, d, ok);
		chkf(ok, 1'h0);
		chkv(11'(d), 11'h000);
		host.io_read({5'h00, cur_base}, d, ok);
		chkf(ok, 1'h1);
		chkv(11'(d), 11'h018);
	endtask
	// strap high, then a mid-run reset reloads the base
	task automatic t_strap();
		@(posedge clk);
		strap <= 1'h1;
		repeat (3) @(posedge clk);
		arst_n <= 1'h0;
		repeat (2) @(posedge clk);
		arst_n <= 1'h1;
		repeat (10) @(posedge clk);
		#1;
		cur_base = 11'h370;
		chkv(base, cur_base);
		expect_reg(8'h12, 8'h70);
		expect_reg(8'h13, 8'h03);
		expect_reg(8'h17, 8'h03);
	endtask
	task automatic t_force();
		wr_reg(8'h17, 8'h00);
		expect_reg(8'h17, 8'h03);
		pins(5'h17, 5'h1f);
		chkf(st.dir_disk_change, 1'h1);
		chkf(st.disk_change_n, 1'h0);
		chkf(st.write_lock_n, 1'h1);
		pins(5'h07, 5'h1f);
		pins(5'h1f, 5'h1f);
		expect_reg(8'h17, 8'h02);
		wr_reg(8'h17, 8'hff);
		expect_reg(8'h17, 8'h07);
		pins(5'h1f, 5'h1b);
		chkf(pp_st.dir_disk_change, 1'h1);
		chkf(pp_st.write_lock_n, 1'h0);
		pins(5'h1f, 5'h0b);
		pins(5'h1c, 5'h1f);
		expect_reg(8'h17, 8'h05);
		chkf(st.write_lock_n, 1'h0);
		chkf(st.dir_disk_change, 1'h1);
		pins(5'h1f, 5'h1f);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'h1;
		repeat (10) @(posedge clk);
		t_defaults();
		t_shadows();
		t_move();
		t_refuse();
		t_force();
		t_strap();
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		finish_test();
	end
endmodule
bind sior_config_regs sior_props u_props (.CLK(CLK), .ARST_N(ARST_N),
	.CONFIG_STATE(CONFIG_STATE), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR),
	.IO_RD(IO_RD), .IO_RDATA(IO_RDATA), .IO_RDATA_OE(IO_RDATA_OE),
	.CONFIG_BASE(CONFIG_BASE), .CONFIG_INDEX(CONFIG_INDEX),
	.DRIVE_ZERO_SELECT_N(DRIVE_ZERO_SELECT_N),
	.DRIVE_ONE_SELECT_N(DRIVE_ONE_SELECT_N),
	.DISK_CHANGE_INPUT_N(DISK_CHANGE_INPUT_N),
	.FLOPPY_CONTROLLER_STATUS(FLOPPY_CONTROLLER_STATUS));
`default_nettype wire
